/* File: hw/fsp_pkg.sv */
// shared constants for the flash status, protection and identification command block
// Operation
// - write disable clears write-enable latch and auto-increment flag to zero
// - write disable is the single opcode byte 04H; host uses it to leave auto-increment
// - write disable does not abort a program operation already running
// - write disable takes effect only on chip-select rising edge after the opcode
// - status-write arm enables only the very next instruction; otherwise arming is lost
// - status-write arm is framed by chip select and takes effect on rising edge
// - write enable also permits status write; latch clears when that write ends
// - write enable sets the write-enable latch to one
// - byte-data status write updates both block-protect bits and the protect-lock bit
// - protect pin low with lock set: status write leaves protect fields unchanged, write-enable latch still clears
// - protect pin low: lock may go from zero to one, never back
// - protect pin high: lock-down off, all protect fields writable
// - permission judged from lock and pin before the ending edge; lock and bits together
// - two data bytes: first to main status, second to second status register
// - status write needs exactly one or two whole bytes, nothing more or less
// - opcode 9FH returns maker byte, then memory-type byte and capacity byte
// - chip-select rise ends identification output at any point and releases output
// - legacy identification accepts opcode 90H or ABH followed by 24-bit address
// - legacy read gives maker code at address 0, device code at address 1
// - legacy read keeps alternating maker and device bytes until chip select rises
package fsp_pkg;

  // ==========================================================================
  // opcodes
  localparam logic [7:0] OP_WRITE_DISABLE   = 8'h04;
  localparam logic [7:0] OP_WRITE_ENABLE    = 8'h06;
  localparam logic [7:0] OP_STATUS_ARM      = 8'h50;
  localparam logic [7:0] OP_STATUS_WRITE    = 8'h01;
  localparam logic [7:0] OP_JEDEC_ID        = 8'h9F;
  localparam logic [7:0] OP_LEGACY_ID_A     = 8'h90;
  localparam logic [7:0] OP_LEGACY_ID_B     = 8'hAB;

  // ==========================================================================
  // identification bytes (values arbitrary)
  localparam logic [7:0] MAKER_CODE_DEF     = 8'h5A;
  localparam logic [7:0] MEM_TYPE_DEF       = 8'h3C;
  localparam logic [7:0] CAPACITY_DEF       = 8'h61;

  // ==========================================================================
  // field positions in the main and second status registers
  localparam int         BP_LOW_POS         = 2;
  localparam int         BP_HIGH_POS        = 3;
  localparam int         LOCK_POS           = 7;
  localparam int         SR2_A_POS          = 3;
  localparam int         SR2_B_POS          = 5;

  // ==========================================================================
  // values after reset
  localparam logic       RST_WEL            = 1'b0;
  localparam logic       RST_AAI            = 1'b0;
  localparam logic       RST_ARMED          = 1'b0;
  localparam logic       RST_BP             = 1'b0;
  localparam logic       RST_LOCK           = 1'b0;
  localparam logic       RST_SR2            = 1'b0;
  // synchroniser order {chip select, protect pin, frame toggle}
  localparam logic [2:0] RST_SYNC           = 3'h4;
  localparam logic       RST_CS_PREV        = 1'b1;

  // ==========================================================================
  // frame byte counts (opcode byte included)
  localparam logic [2:0] CNT_OPCODE_ONLY    = 3'h1;
  localparam logic [2:0] CNT_STATUS_BYTE    = 3'h2;
  localparam logic [2:0] CNT_STATUS_WORD    = 3'h3;
  localparam logic [2:0] CNT_JEDEC_MAKER    = 3'h1;
  localparam logic [2:0] CNT_JEDEC_TYPE     = 3'h2;
  localparam logic [2:0] CNT_JEDEC_CAP      = 3'h3;
  localparam logic [2:0] CNT_ADDR_LAST      = 3'h3;
  localparam logic [2:0] CNT_LEGACY_DATA    = 3'h4;
  localparam logic [2:0] CNT_SATURATE       = 3'h7;
  localparam logic [2:0] BIT_LAST           = 3'h7;
  localparam int         SYNC_STAGES        = 2;

endpackage

/* File: hw/fsp_sync.sv */
// multi-bit two-stage level synchroniser into the system clock domain
`timescale 1ns/1ns
module fsp_sync #(
  parameter int             WIDTH   = 3,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input  wire logic             clk_in,
  input  wire logic             rst_b_in,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  // ==========================================================================
  // stage one feeds stage two only
  logic [WIDTH-1:0] meta;

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      meta     <= RST_VAL;
      sync_out <= RST_VAL;
    end else begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end

endmodule

/* File: hw/fsp_flash_status_protect_id.sv */
// serial flash command logic: write disable, armed status write, identification reads
`timescale 1ns/1ns
module fsp_flash_status_protect_id #(
  parameter logic [7:0] OP_ARM      = fsp_pkg::OP_STATUS_ARM,
  parameter logic [7:0] OP_SWRITE   = fsp_pkg::OP_STATUS_WRITE,
  parameter logic [7:0] OP_WEN      = fsp_pkg::OP_WRITE_ENABLE,
  parameter int         P_BP_LOW    = fsp_pkg::BP_LOW_POS,
  parameter int         P_BP_HIGH   = fsp_pkg::BP_HIGH_POS,
  parameter int         P_LOCK      = fsp_pkg::LOCK_POS,
  parameter int         P_SR2_A     = fsp_pkg::SR2_A_POS,
  parameter int         P_SR2_B     = fsp_pkg::SR2_B_POS,
  parameter logic [7:0] MAKER_CODE  = fsp_pkg::MAKER_CODE_DEF,
  parameter logic [7:0] MEM_TYPE    = fsp_pkg::MEM_TYPE_DEF,
  parameter logic [7:0] CAPACITY    = fsp_pkg::CAPACITY_DEF
) (
  input  wire logic clk_in,
  input  wire logic rst_b_in,
  input  wire logic sck_in,
  input  wire logic cs_b_in,
  input  wire logic si_in,
  output logic      so_out,
  output logic      so_oe_out,
  input  wire logic wp_b_in,
  input  wire logic aai_set_in,
  output logic      write_enable_latch_out,
  output logic      auto_increment_program_flag_out,
  output logic      block_protect_low_out,
  output logic      block_protect_high_out,
  output logic      protect_lock_out,
  output logic      second_reg_protect_a_out,
  output logic      second_reg_protect_b_out,
  output logic      status_write_armed_out
);

  // ==========================================================================
  // link clock domain: frame capture on rising serial clock
  // chip select high clears the in-frame marker at once, so a new
  // frame restarts counting even though the serial clock may be stopped
  logic       frame_rst_b;
  logic       in_frame;
  logic [2:0] bit_cnt;
  logic [2:0] byte_cnt;
  logic       byte_par;
  logic [7:0] rx_sh;
  logic [7:0] opcode;
  logic [7:0] data_a;
  logic [7:0] data_b;
  logic       addr_lsb;
  logic       frame_tog;

  assign frame_rst_b = rst_b_in & ~cs_b_in;

  always_ff @(posedge sck_in or negedge frame_rst_b) begin
    if (!frame_rst_b) begin
      in_frame <= 1'b0;
    end else begin
      in_frame <= 1'b1;
    end
  end

  logic [2:0] cur_bit;
  logic [2:0] cur_byte;
  logic       cur_par;
  logic       byte_done;
  logic [7:0] rx_byte;
  logic [2:0] next_bit_cnt;
  logic [2:0] next_byte_cnt;
  logic       next_byte_par;
  logic       next_frame_tog;

  assign cur_bit        = in_frame ? bit_cnt : 3'h0;
  assign cur_byte       = in_frame ? byte_cnt : 3'h0;
  assign cur_par        = in_frame ? byte_par : 1'b0;
  assign byte_done      = (cur_bit == fsp_pkg::BIT_LAST);
  // input sampled on rising clock only, which serves modes 0 and 3
  assign rx_byte        = {rx_sh[6:0], si_in};
  assign next_bit_cnt   = cur_bit + 3'h1;
  assign next_byte_cnt  = (byte_done && cur_byte != fsp_pkg::CNT_SATURATE)
                          ? cur_byte + 3'h1 : cur_byte;
  assign next_byte_par  = byte_done ? ~cur_par : cur_par;
  // toggles once per frame so the system side can tell a clocked frame
  // from a bare chip-select pulse with stale counts behind it
  assign next_frame_tog = in_frame ? frame_tog : ~frame_tog;

  always_ff @(posedge sck_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      bit_cnt   <= 3'h0;
      byte_cnt  <= 3'h0;
      byte_par  <= 1'b0;
      rx_sh     <= 8'h00;
      frame_tog <= 1'b0;
    end else begin
      bit_cnt   <= next_bit_cnt;
      byte_cnt  <= next_byte_cnt;
      byte_par  <= next_byte_par;
      rx_sh     <= rx_byte;
      frame_tog <= next_frame_tog;
    end
  end

  logic cap_opcode;
  logic cap_data_a;
  logic cap_data_b;
  logic cap_addr;

  assign cap_opcode = byte_done && (cur_byte == 3'h0);
  assign cap_data_a = byte_done && (cur_byte == fsp_pkg::CNT_OPCODE_ONLY);
  assign cap_data_b = byte_done && (cur_byte == fsp_pkg::CNT_STATUS_BYTE);
  assign cap_addr   = byte_done && (cur_byte == fsp_pkg::CNT_ADDR_LAST);

  always_ff @(posedge sck_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      opcode   <= 8'h00;
      data_a   <= 8'h00;
      data_b   <= 8'h00;
      addr_lsb <= 1'b0;
    end else begin
      if (cap_opcode) begin
        opcode <= rx_byte;
      end
      if (cap_data_a) begin
        data_a <= rx_byte;
      end
      if (cap_data_b) begin
        data_b <= rx_byte;
      end
      if (cap_addr) begin
        addr_lsb <= si_in;
      end
    end
  end

  // ==========================================================================
  // link clock domain: identification output on falling serial clock
  logic       is_jedec;
  logic       is_legacy;
  logic       jedec_drive;
  logic       legacy_drive;
  logic       id_drive;
  logic       legacy_pick_dev;
  logic [7:0] jedec_byte;
  logic [7:0] legacy_byte;
  logic [7:0] tx_byte;
  logic [7:0] tx_sh;
  logic       load_byte;

  assign is_jedec        = (opcode == fsp_pkg::OP_JEDEC_ID);
  assign is_legacy       = (opcode == fsp_pkg::OP_LEGACY_ID_A) ||
                           (opcode == fsp_pkg::OP_LEGACY_ID_B);
  assign jedec_drive     = is_jedec && (byte_cnt >= fsp_pkg::CNT_JEDEC_MAKER);
  // data follows the opcode and three address bytes
  assign legacy_drive    = is_legacy && (byte_cnt >= fsp_pkg::CNT_LEGACY_DATA);
  assign id_drive        = in_frame && (jedec_drive || legacy_drive);
  // first data byte has even parity, so address bit 0 picks the start
  // and each further byte flips to the other code
  assign legacy_pick_dev = addr_lsb ^ byte_par;
  assign legacy_byte     = legacy_pick_dev ? CAPACITY : MAKER_CODE;
  assign jedec_byte      = (byte_cnt == fsp_pkg::CNT_JEDEC_MAKER) ? MAKER_CODE :
                           (byte_cnt == fsp_pkg::CNT_JEDEC_TYPE)  ? MEM_TYPE   :
                           (byte_cnt == fsp_pkg::CNT_JEDEC_CAP)   ? CAPACITY   :
                           8'h00;
  assign tx_byte         = is_jedec ? jedec_byte : legacy_byte;
  assign load_byte       = (bit_cnt == 3'h0);

  // chip select high resets this stage asynchronously, so output is
  // released at once even mid-byte with the serial clock stopped
  always_ff @(negedge sck_in or negedge frame_rst_b) begin
    if (!frame_rst_b) begin
      so_out    <= 1'b0;
      so_oe_out <= 1'b0;
      tx_sh     <= 8'h00;
    end else if (!id_drive) begin
      so_out    <= 1'b0;
      so_oe_out <= 1'b0;
      tx_sh     <= 8'h00;
    end else if (load_byte) begin
      so_out    <= tx_byte[7];
      so_oe_out <= 1'b1;
      tx_sh     <= {tx_byte[6:0], 1'b0};
    end else begin
      so_out    <= tx_sh[7];
      so_oe_out <= 1'b1;
      tx_sh     <= {tx_sh[6:0], 1'b0};
    end
  end

  // ==========================================================================
  // crossing into the system clock domain
  // the captured frame words are read only after chip select is seen high
  // through the synchroniser; the serial clock is idle then, so they are
  // static and need no further crossing
  logic [2:0] sync_bus;
  logic       cs_s;
  logic       wp_s;
  logic       tog_s;

  fsp_sync #(
    .WIDTH   (3),
    .RST_VAL (fsp_pkg::RST_SYNC)
  ) u_sync (
    .clk_in   (clk_in),
    .rst_b_in (rst_b_in),
    .async_in ({cs_b_in, wp_b_in, frame_tog}),
    .sync_out (sync_bus)
  );

  assign cs_s  = sync_bus[2];
  assign wp_s  = sync_bus[1];
  assign tog_s = sync_bus[0];

  logic cs_prev;
  logic seen_tog;
  logic end_evt;
  logic frame_ok;

  assign end_evt  = cs_s & ~cs_prev;
  assign frame_ok = end_evt && (tog_s != seen_tog);

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cs_prev  <= fsp_pkg::RST_CS_PREV;
      seen_tog <= 1'b0;
    end else begin
      cs_prev  <= cs_s;
      seen_tog <= end_evt ? tog_s : seen_tog;
    end
  end

  // ==========================================================================
  // command decode at the end of a frame
  logic whole_bytes;
  logic one_byte;
  logic cmd_write_disable_cmd;
  logic cmd_write_enable_cmd;
  logic cmd_arm;
  logic swrite_len_ok;
  logic swrite_word;
  logic swrite_go;
  logic write_ok;
  logic swrite_apply;
  logic swrite_sr2;

  assign whole_bytes   = (bit_cnt == 3'h0);
  assign one_byte      = whole_bytes && (byte_cnt == fsp_pkg::CNT_OPCODE_ONLY);
  // single-byte opcodes act only on the closing chip-select edge
  assign cmd_write_disable_cmd      = frame_ok && one_byte &&
                         (opcode == fsp_pkg::OP_WRITE_DISABLE);
  assign cmd_write_enable_cmd      = frame_ok && one_byte && (opcode == OP_WEN);
  assign cmd_arm       = frame_ok && one_byte && (opcode == OP_ARM);
  // a partial byte or anything past the second data byte kills the write
  assign swrite_len_ok = whole_bytes &&
                         ((byte_cnt == fsp_pkg::CNT_STATUS_BYTE) ||
                          (byte_cnt == fsp_pkg::CNT_STATUS_WORD));
  assign swrite_word   = (byte_cnt == fsp_pkg::CNT_STATUS_WORD);
  assign swrite_go     = frame_ok && swrite_len_ok && (opcode == OP_SWRITE) &&
                         (status_write_armed_out || write_enable_latch_out);
  // judged from the lock bit and protect pin as they stand before the edge
  assign write_ok      = wp_s || !protect_lock_out;
  assign swrite_apply  = swrite_go && write_ok;
  assign swrite_sr2    = swrite_apply && swrite_word;

  // ==========================================================================
  // next values of the latches and status fields
  logic next_wel;
  logic next_aai;
  logic next_armed;
  logic next_bp_low;
  logic next_bp_high;
  logic next_lock;
  logic next_sr2_a;
  logic next_sr2_b;

  // write disable wins over a same-frame enable; they cannot share a frame
  assign next_wel     = (cmd_write_disable_cmd || swrite_go) ? 1'b0 :
                        cmd_write_enable_cmd ? 1'b1 :
                        write_enable_latch_out;
  // a set from the program logic beats a write-disable clear in the same cycle
  assign next_aai     = aai_set_in ||
                        (auto_increment_program_flag_out && !cmd_write_disable_cmd);
  // any completed frame other than the arm itself consumes the arming
  assign next_armed   = cmd_arm ? 1'b1 :
                        frame_ok ? 1'b0 : status_write_armed_out;
  assign next_bp_low  = swrite_apply ? data_a[P_BP_LOW] : block_protect_low_out;
  assign next_bp_high = swrite_apply ? data_a[P_BP_HIGH] : block_protect_high_out;
  // with the pin low the write only gets here while the lock is clear,
  // so the lock can rise but never fall
  assign next_lock    = swrite_apply ? data_a[P_LOCK] : protect_lock_out;
  assign next_sr2_a   = swrite_sr2 ? data_b[P_SR2_A] : second_reg_protect_a_out;
  assign next_sr2_b   = swrite_sr2 ? data_b[P_SR2_B] : second_reg_protect_b_out;

  // write disable only touches the latches; a program already running
  // elsewhere keeps its own timer and is never stopped from here
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      write_enable_latch_out          <= fsp_pkg::RST_WEL;
      auto_increment_program_flag_out <= fsp_pkg::RST_AAI;
      status_write_armed_out          <= fsp_pkg::RST_ARMED;
    end else begin
      write_enable_latch_out          <= next_wel;
      auto_increment_program_flag_out <= next_aai;
      status_write_armed_out          <= next_armed;
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      block_protect_low_out    <= fsp_pkg::RST_BP;
      block_protect_high_out   <= fsp_pkg::RST_BP;
      protect_lock_out         <= fsp_pkg::RST_LOCK;
      second_reg_protect_a_out <= fsp_pkg::RST_SR2;
      second_reg_protect_b_out <= fsp_pkg::RST_SR2;
    end else begin
      block_protect_low_out    <= next_bp_low;
      block_protect_high_out   <= next_bp_high;
      protect_lock_out         <= next_lock;
      second_reg_protect_a_out <= next_sr2_a;
      second_reg_protect_b_out <= next_sr2_b;
    end
  end

endmodule

/* File: testbench/fsp_flash_status_protect_id_properties.sv */
// assertion checker for the flash status, protection and identification block
`timescale 1ns/1ns
module fsp_status_checker (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic cs_b_in,
  input wire logic so_out,
  input wire logic so_oe_out,
  input wire logic wp_b_in,
  input wire logic aai_set_in,
  input wire logic write_enable_latch_out,
  input wire logic auto_increment_program_flag_out,
  input wire logic block_protect_low_out,
  input wire logic block_protect_high_out,
  input wire logic protect_lock_out,
  input wire logic second_reg_protect_a_out,
  input wire logic second_reg_protect_b_out,
  input wire logic status_write_armed_out
);
  // ==========================================================================
  // properties
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_b_in);
  AST_SO_RELEASE: assert property (cs_b_in |-> !so_oe_out && !so_out)
    else $error("serial output driven while deselected");
  AST_OE_IN_FRAME: assert property ($rose(so_oe_out) |-> !cs_b_in)
    else $error("output enabled outside a frame");
  AST_WEL_AFTER_FRAME: assert property ($rose(write_enable_latch_out) |-> $past(cs_b_in) && $past(cs_b_in, 2))
    else $error("latch set before frame end was seen");
  AST_PROT_AFTER_FRAME: assert property ($changed({block_protect_low_out, block_protect_high_out,
    protect_lock_out, second_reg_protect_a_out, second_reg_protect_b_out}) |-> $past(cs_b_in) && $past(cs_b_in, 2))
    else $error("protect field changed inside a frame");
  AST_LOCK_HELD_WP_LOW: assert property ($fell(protect_lock_out) |-> $past(wp_b_in, 4))
    else $error("lock cleared with protect pin low");
  // bench keeps the protect pin steady for long spans around frames
  AST_LOCKED_FROZEN: assert property ($past(protect_lock_out) && !$past(wp_b_in, 5) && !wp_b_in
    |-> $stable({block_protect_low_out, block_protect_high_out, second_reg_protect_a_out, second_reg_protect_b_out}))
    else $error("protect fields changed while locked");
  // holds only because the bench never sends two arm frames in a row
  AST_ARM_ONE_SHOT: assert property (status_write_armed_out && !cs_b_in ##1 cs_b_in
    |-> ##[1:6] !status_write_armed_out)
    else $error("arming survived the next frame");
  AST_AAI_CLEAR: assert property ($fell(auto_increment_program_flag_out)
    |-> $past(cs_b_in) && $past(cs_b_in, 2) && !$past(aai_set_in))
    else $error("auto-increment flag cleared without a command");
endmodule
bind fsp_flash_status_protect_id fsp_status_checker u_chk (
  .clk_in(clk_in), .rst_b_in(rst_b_in), .cs_b_in(cs_b_in), .so_out(so_out), .so_oe_out(so_oe_out),
  .wp_b_in(wp_b_in), .aai_set_in(aai_set_in), .write_enable_latch_out(write_enable_latch_out),
  .auto_increment_program_flag_out(auto_increment_program_flag_out),
  .block_protect_low_out(block_protect_low_out), .block_protect_high_out(block_protect_high_out),
  .protect_lock_out(protect_lock_out), .second_reg_protect_a_out(second_reg_protect_a_out),
  .second_reg_protect_b_out(second_reg_protect_b_out), .status_write_armed_out(status_write_armed_out)
);

/* File: testbench/fsp_host.sv */
// serial host model: frames commands, clocks mode 0, captures the reply
`timescale 1ns/1ns
module fsp_host (
  output logic      sck_out,
  output logic      cs_b_out,
  output logic      si_out,
  input  wire logic so_in,
  input  wire logic so_oe_in
);
  initial begin
    sck_out = 1'b0;
    cs_b_out = 1'b1;
    si_out = 1'b0;
  end
  // ==========================================================================
  // one frame; clock stands still at 0 outside frames
  task automatic xfer(input logic [63:0] tx, input int nbits, output logic [63:0] rx);
    rx = '0;
    cs_b_out = 1'b0;
    #20;
    for (int i = 0; i < nbits; i++) begin
      si_out = tx[63-i];
      #62 sck_out = 1'b1;
      rx = {rx[62:0], so_in & so_oe_in};
      #63 sck_out = 1'b0;
    end
    #20 cs_b_out = 1'b1;
    // released data line shows the inverse so a stale bit is never trusted
    si_out = ~si_out;
    #100;
  endtask
endmodule

/* File: testbench/tb_flash_status_protect_id.sv */
// self-checking bench for the flash status, protection and identification block
`timescale 1ns/1ns
module tb_flash_status_protect_id;
  logic        clk_in;
  logic        rst_b_in;
  logic        wp_b_in;
  logic        aai_set_in;
  logic [63:0] rx;
  int          fails;
  int          cmp_count;
  wire         sck, cs_b, si, so, so_oe;
  wire         write_enable_latch, auto_increment_program_flag, lock, bph, protect_lock, sra, srb, arm;

  fsp_flash_status_protect_id u_dut (
    .clk_in(clk_in), .rst_b_in(rst_b_in), .sck_in(sck), .cs_b_in(cs_b), .si_in(si), .so_out(so),
    .so_oe_out(so_oe), .wp_b_in(wp_b_in), .aai_set_in(aai_set_in), .write_enable_latch_out(write_enable_latch),
    .auto_increment_program_flag_out(auto_increment_program_flag), .block_protect_low_out(protect_lock), .block_protect_high_out(bph),
    .protect_lock_out(lock), .second_reg_protect_a_out(sra), .second_reg_protect_b_out(srb),
    .status_write_armed_out(arm)
  );
  fsp_host u_host (.sck_out(sck), .cs_b_out(cs_b), .si_out(si), .so_in(so), .so_oe_in(so_oe));

  // ==========================================================================
  // tasks
  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic f(input logic [63:0] tx, input int n);
    u_host.xfer(tx, n, rx);
  endtask
  // status order: latch, aai, lock, bp high, bp low, second b, second a, armed
  task automatic st(input logic [7:0] exp);
    chk({16'h0000, write_enable_latch, auto_increment_program_flag, lock, bph, protect_lock, srb, sra, arm}, {16'h0000, exp});
  endtask
  task automatic test_done;
    if (fails == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // ==========================================================================
  // clock and watchdog
  initial begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end
  initial begin
    #300000;
    fails++;
    test_done();
  end

  // ==========================================================================
  // tests
  initial begin
    fails = 0;
    cmp_count = 0;
    rst_b_in = 1'b0;
    wp_b_in = 1'b1;
    aai_set_in = 1'b0;
    repeat (3) @(posedge clk_in);
    rst_b_in <= 1'b1;
    repeat (8) @(posedge clk_in);
    f({fsp_pkg::OP_WRITE_ENABLE, 56'h0}, 8);
    st(8'h80);
    @(posedge clk_in);
    aai_set_in <= 1'b1;
    @(posedge clk_in);
    aai_set_in <= 1'b0;
    #5;
    st(8'hC0);
    f({8'h04, 56'h0}, 8);
    st(8'h00);
    f({fsp_pkg::OP_STATUS_ARM, 56'h0}, 8);
    st(8'h01);
    f({fsp_pkg::OP_STATUS_WRITE, 8'h8C, 48'h0}, 16);
    st(8'h38);
    f({fsp_pkg::OP_STATUS_ARM, 56'h0}, 8);
    f({8'h9F, 56'h0}, 32);
    chk(rx[23:0], {fsp_pkg::MAKER_CODE_DEF, fsp_pkg::MEM_TYPE_DEF, fsp_pkg::CAPACITY_DEF});
    f({fsp_pkg::OP_STATUS_WRITE, 8'h00, 48'h0}, 16);
    st(8'h38);
    f({fsp_pkg::OP_WRITE_ENABLE, 56'h0}, 8);
    f({fsp_pkg::OP_STATUS_WRITE, 16'h0028, 40'h0}, 24);
    st(8'h06);
    @(posedge clk_in);
    wp_b_in <= 1'b0;
    f({fsp_pkg::OP_WRITE_ENABLE, 56'h0}, 8);
    f({fsp_pkg::OP_STATUS_WRITE, 8'h84, 48'h0}, 16);
    st(8'h2E);
    f({fsp_pkg::OP_WRITE_ENABLE, 56'h0}, 8);
    f({fsp_pkg::OP_STATUS_WRITE, 16'h0000, 40'h0}, 24);
    st(8'h2E);
    @(posedge clk_in);
    wp_b_in <= 1'b1;
    f({fsp_pkg::OP_WRITE_ENABLE, 56'h0}, 8);
    f({fsp_pkg::OP_STATUS_WRITE, 56'h0}, 12);
    st(8'hAE);
    f({fsp_pkg::OP_STATUS_WRITE, 56'h0}, 19);
    st(8'hAE);
    f({fsp_pkg::OP_STATUS_WRITE, 56'h0}, 16);
    st(8'h06);
    f({8'h9F, 56'h0}, 12);
    chk({20'h00000, rx[3:0]}, {20'h00000, fsp_pkg::MAKER_CODE_DEF[7:4]});
    for (int k = 0; k < 4; k++) begin
      f({(k[1] ? 8'hAB : 8'h90), 23'h0, k[0], 32'h0}, 48);
      chk({8'h00, rx[15:0]}, k[0] ? {8'h00, fsp_pkg::CAPACITY_DEF, fsp_pkg::MAKER_CODE_DEF}
                                  : {8'h00, fsp_pkg::MAKER_CODE_DEF, fsp_pkg::CAPACITY_DEF});
    end
    test_done();
  end
endmodule
